// File: common/ppc_pkg.sv
// constants, register map and state type of the port controller control block
// assumes a single 40 MHz clock domain; included by package reference only
package ppc_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [7:0] REG_INT_EVENT   = 8'h00;
	localparam logic [7:0] REG_INT_MASK    = 8'h01;
	localparam logic [7:0] REG_PIN_STATUS  = 8'h11;
	localparam logic [7:0] REG_PORT_CTRL   = 8'h12;
	localparam logic [7:0] REG_PORT_STATUS = 8'h13;
	localparam logic [7:0] REG_PUSHBUTTON  = 8'h1a;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [7:0] INT_EVENT_RST        = 8'h80;
	localparam logic [7:0] MASK_RST_MANUAL      = 8'h80;
	localparam logic [7:0] MASK_RST_AUTO        = 8'he4;
	localparam logic [7:0] PORT_CTRL_RST_MANUAL = 8'h00;
	localparam logic [7:0] PORT_CTRL_RST_AUTO   = 8'h0f;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int         EV_TSTART    = 6;
	localparam int         EV_TICUT     = 5;
	localparam int         EV_PGOOD     = 1;
	localparam int         EV_PENABLE   = 0;
	localparam int         PB_INT_LO    = 6;
	localparam int         PB_INT_HI    = 7;
	localparam int         PIN_AUTO_BIT = 0;
	localparam logic [2:0] ADDR_PREFIX  = 3'h2;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_NS        = 25;
	localparam int GLITCH_NS     = 1000;
	localparam int GLITCH_CYC    = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
	localparam int FAULT_TIME_US = 1000;
	localparam int FAULT_CYC     = FAULT_TIME_US * 1000 / CLK_NS;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_REG,
		ST_REG_ACK,
		ST_WDATA,
		ST_WDATA_ACK,
		ST_RDATA,
		ST_RDATA_ACK
	} ppc_i2c_state_t;

endpackage

// File: src/ppc_filter.sv
// three-flop synchroniser with a stability filter for one pin
// assumes STABLE_CYC below 128; reset is synchronous, active high
`timescale 1ns/100ps
module ppc_filter #(
	parameter int   STABLE_CYC = 1,
	parameter logic INIT       = 1'b1
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic pin,
	output logic      level
);
	logic       s1_reg;
	logic       s2_reg;
	logic       s3_reg;
	logic       level_reg;
	logic [6:0] cnt_reg;

	assign level = level_reg;

	// ****************************************************************
	// sync and filter
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s1_reg    <= INIT;
			s2_reg    <= INIT;
			s3_reg    <= INIT;
			level_reg <= INIT;
			cnt_reg   <= 7'h00;
		end
		else
		begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg && s3_reg != level_reg)
			begin
				if (cnt_reg >= 7'(STABLE_CYC - 1))
				begin
					level_reg <= s3_reg;
					cnt_reg   <= 7'h00;
				end
				else
					cnt_reg <= cnt_reg + 7'h01;
			end
			else
				cnt_reg <= 7'h00;
		end
	end
endmodule

// File: src/ppc_port.sv
// one power port: fault timer, gate control, power good, ac probe routing
// assumes comparator levels already synchronised to clk
`timescale 1ns/100ps
module ppc_port #(
	parameter int FAULT_CYC = ppc_pkg::FAULT_CYC
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic enable,
	input  wire logic over_cut,
	input  wire logic at_clamp,
	input  wire logic out_low,
	input  wire logic osc,
	input  wire logic ac_en,
	output logic      gate_on,
	output logic      throttle,
	output logic      pg,
	output logic      probe,
	output logic      tstart_ev,
	output logic      ticut_ev,
	output logic      pg_ev,
	output logic      pe_ev
);
	logic [22:0] fault_cnt_reg;
	logic        tripped_reg;
	logic        gate_reg;
	logic        throttle_reg;
	logic        pg_reg;
	logic        probe_reg;
	logic        tstart_reg;
	logic        ticut_reg;
	logic        pg_ev_reg;
	logic        pe_ev_reg;
	logic        expire;
	logic        gate_next;

	assign expire    = gate_reg && over_cut && fault_cnt_reg == 23'(FAULT_CYC - 1);
	assign gate_next = enable && !tripped_reg && !expire;
	assign gate_on   = gate_reg;
	assign throttle  = throttle_reg;
	assign pg        = pg_reg;
	assign probe     = probe_reg;
	assign tstart_ev = tstart_reg;
	assign ticut_ev  = ticut_reg;
	assign pg_ev     = pg_ev_reg;
	assign pe_ev     = pe_ev_reg;

	// ****************************************************************
	// fault timer and gate
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			fault_cnt_reg <= 23'h000000;
			tripped_reg   <= 1'b0;
			gate_reg      <= 1'b0;
			throttle_reg  <= 1'b0;
		end
		else
		begin
			if (!gate_reg || !over_cut)
				fault_cnt_reg <= 23'h000000;
			else if (!expire)
				fault_cnt_reg <= fault_cnt_reg + 23'h000001;
			if (expire)
				tripped_reg <= 1'b1;
			else if (!enable)
				tripped_reg <= 1'b0;
			gate_reg     <= gate_next;
			throttle_reg <= gate_next && at_clamp;
		end
	end

	// ****************************************************************
	// status and events
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pg_reg     <= 1'b0;
			probe_reg  <= 1'b0;
			tstart_reg <= 1'b0;
			ticut_reg  <= 1'b0;
			pg_ev_reg  <= 1'b0;
			pe_ev_reg  <= 1'b0;
		end
		else
		begin
			pg_reg     <= gate_reg && out_low;
			probe_reg  <= gate_reg && ac_en && osc;
			tstart_reg <= expire && !pg_reg;
			ticut_reg  <= expire && pg_reg;
			pg_ev_reg  <= (gate_reg && out_low) != pg_reg;
			pe_ev_reg  <= gate_next != gate_reg;
		end
	end

	fault_off_a: assert property (@(posedge clk) disable iff (rst)
		expire |=> !gate_reg ##1 !gate_reg)
		else $error("gate still on after fault timer expiry");

	timer_step_a: assert property (@(posedge clk) disable iff (rst)
		(gate_reg && over_cut && !expire) |=> fault_cnt_reg == $past(fault_cnt_reg) + 23'h000001)
		else $error("fault timer did not advance");

	pg_set_a: assert property (@(posedge clk) disable iff (rst)
		pg_reg |-> $past(gate_reg) && $past(out_low))
		else $error("power good without low output voltage");

	probe_route_a: assert property (@(posedge clk) disable iff (rst)
		probe_reg |-> $past(osc) && $past(ac_en) && $past(gate_reg))
		else $error("probe driven while port unpowered or disabled");
endmodule

// File: src/ppc_top.sv
// control logic of a four-port power-sourcing controller with a split-pin
// serial slave; assumes a 40 MHz clk and analog comparators outside
`timescale 1ns/100ps

module ppc_top #(
	parameter int FAULT_CYC = ppc_pkg::FAULT_CYC
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       chip_reset_n,
	input  wire logic       scl,
	input  wire logic       serial_data_sense_pin,
	output logic            serial_data_drive_pin,
	output logic            serial_data_drive_pin_oe,
	output logic            int_pin,
	output logic            int_pin_oe,
	input  wire logic       bus_addr_strap_msb,
	input  wire logic       bus_addr_strap_2,
	input  wire logic       bus_addr_strap_1,
	input  wire logic       bus_addr_strap_lsb,
	input  wire logic       auto_mode_strap,
	input  wire logic [3:0] port_shutoff_n,
	input  wire logic [3:0] port_current_monitor_cut,
	input  wire logic [3:0] port_current_monitor_clamp,
	input  wire logic [3:0] port_voltage_monitor_low,
	input  wire logic       ac_probe_oscillator_input,
	output logic      [3:0] port_fet_drive,
	output logic      [3:0] port_fet_throttle,
	output logic      [3:0] port_power_good,
	output logic      [3:0] port_probe_pin
);
	ppc_pkg::ppc_i2c_state_t state_reg;
	logic       chip_rst_lvl;
	logic       rst_int;
	logic       scl_lvl;
	logic       sda_lvl;
	logic       auto_lvl;
	logic       osc_lvl;
	logic [3:0] strap_lvl;
	logic [3:0] strap_pin;
	logic [3:0] shut_lvl;
	logic [3:0] cut_lvl;
	logic [3:0] clamp_lvl;
	logic [3:0] low_lvl;
	logic [3:0] gate_on;
	logic [3:0] pg;
	logic [3:0] tstart_ev;
	logic [3:0] ticut_ev;
	logic [3:0] pg_ev;
	logic [3:0] pe_ev;
	logic       scl_d_reg;
	logic       sda_d_reg;
	logic       busy_reg;
	logic       sda_oe_reg;
	logic       int_oe_reg;
	logic       rw_reg;
	logic       nack_reg;
	logic       wr_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] ptr_reg;
	logic [7:0] mask_reg;
	logic [7:0] ctrl_reg;
	logic [7:0] ctrl_next;
	logic [7:0] ev_reg;
	logic [7:0] ev_set;
	logic [7:0] ev_clr;
	logic [7:0] rd_data;
	logic [6:0] dev_addr;
	logic       start;
	logic       stop;
	logic       scl_rise;
	logic       scl_fall;
	logic       wr_pb;

	// ****************************************************************
	// input synchronisers
	// ****************************************************************
	assign strap_pin = {bus_addr_strap_msb, bus_addr_strap_2, bus_addr_strap_1,
		bus_addr_strap_lsb};

	ppc_filter #(.STABLE_CYC(ppc_pkg::GLITCH_CYC), .INIT(1'b0)) rst_filt (
		.clk(clk), .sys_rst(sys_rst), .pin(chip_reset_n), .level(chip_rst_lvl));
	ppc_filter scl_filt (
		.clk(clk), .sys_rst(sys_rst), .pin(scl), .level(scl_lvl));
	ppc_filter sda_filt (
		.clk(clk), .sys_rst(sys_rst), .pin(serial_data_sense_pin), .level(sda_lvl));
	ppc_filter #(.INIT(1'b0)) auto_filt (
		.clk(clk), .sys_rst(sys_rst), .pin(auto_mode_strap), .level(auto_lvl));
	ppc_filter #(.INIT(1'b0)) osc_filt (
		.clk(clk), .sys_rst(sys_rst), .pin(ac_probe_oscillator_input), .level(osc_lvl));

	assign rst_int = sys_rst || !chip_rst_lvl;

	// ****************************************************************
	// per-port logic
	// ****************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_port
			ppc_filter #(.INIT(1'b0)) strap_f (
				.clk(clk), .sys_rst(sys_rst), .pin(strap_pin[gi]), .level(strap_lvl[gi]));
			ppc_filter #(.STABLE_CYC(ppc_pkg::GLITCH_CYC)) shut_f (
				.clk(clk), .sys_rst(sys_rst), .pin(port_shutoff_n[gi]), .level(shut_lvl[gi]));
			ppc_filter #(.INIT(1'b0)) cut_f (
				.clk(clk), .sys_rst(sys_rst), .pin(port_current_monitor_cut[gi]),
				.level(cut_lvl[gi]));
			ppc_filter #(.INIT(1'b0)) clamp_f (
				.clk(clk), .sys_rst(sys_rst), .pin(port_current_monitor_clamp[gi]),
				.level(clamp_lvl[gi]));
			ppc_filter #(.INIT(1'b0)) low_f (
				.clk(clk), .sys_rst(sys_rst), .pin(port_voltage_monitor_low[gi]),
				.level(low_lvl[gi]));
			ppc_port #(.FAULT_CYC(FAULT_CYC)) port_u (
				.clk(clk),
				.rst(rst_int),
				.enable(ctrl_reg[gi] && shut_lvl[gi]),
				.over_cut(cut_lvl[gi]),
				.at_clamp(clamp_lvl[gi]),
				.out_low(low_lvl[gi]),
				.osc(osc_lvl),
				.ac_en(ctrl_reg[gi + 4]),
				.gate_on(gate_on[gi]),
				.throttle(port_fet_throttle[gi]),
				.pg(pg[gi]),
				.probe(port_probe_pin[gi]),
				.tstart_ev(tstart_ev[gi]),
				.ticut_ev(ticut_ev[gi]),
				.pg_ev(pg_ev[gi]),
				.pe_ev(pe_ev[gi]));
		end
	endgenerate

	assign port_fet_drive  = gate_on;
	assign port_power_good = pg;

	// ****************************************************************
	// bus conditions
	// ****************************************************************
	assign dev_addr = {ppc_pkg::ADDR_PREFIX, strap_lvl};
	assign start    = scl_lvl && scl_d_reg && sda_d_reg && !sda_lvl;
	assign stop     = scl_lvl && scl_d_reg && !sda_d_reg && sda_lvl;
	assign scl_rise = scl_lvl && !scl_d_reg;
	assign scl_fall = !scl_lvl && scl_d_reg;

	always_ff @(posedge clk)
	begin
		if (rst_int)
		begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			busy_reg  <= 1'b0;
		end
		else
		begin
			scl_d_reg <= scl_lvl;
			sda_d_reg <= sda_lvl;
			if (start)
				busy_reg <= 1'b1;
			else if (stop)
				busy_reg <= 1'b0;
		end
	end

	// ****************************************************************
	// serial slave
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (rst_int)
		begin
			state_reg   <= ppc_pkg::ST_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg   <= 8'h00;
			ptr_reg     <= 8'h00;
			rw_reg      <= 1'b0;
			nack_reg    <= 1'b0;
			sda_oe_reg  <= 1'b0;
			wr_reg      <= 1'b0;
		end
		else
		begin
			wr_reg <= 1'b0;
			if (start)
			begin
				state_reg   <= ppc_pkg::ST_ADDR;
				bit_cnt_reg <= 4'h0;
				sda_oe_reg  <= 1'b0;
			end
			else if (stop)
			begin
				state_reg  <= ppc_pkg::ST_IDLE;
				sda_oe_reg <= 1'b0;
			end
			else if (scl_rise)
			begin
				if (state_reg == ppc_pkg::ST_ADDR || state_reg == ppc_pkg::ST_REG ||
					state_reg == ppc_pkg::ST_WDATA)
				begin
					shift_reg   <= {shift_reg[6:0], sda_lvl};
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end
				else if (state_reg == ppc_pkg::ST_RDATA_ACK)
					nack_reg <= sda_lvl;
			end
			else if (scl_fall)
			begin
				unique case (state_reg)
					ppc_pkg::ST_IDLE:
						;
					ppc_pkg::ST_ADDR:
						if (bit_cnt_reg == 4'h8)
						begin
							if (shift_reg[7:1] == dev_addr)
							begin
								state_reg  <= ppc_pkg::ST_ADDR_ACK;
								sda_oe_reg <= 1'b1;
								rw_reg     <= shift_reg[0];
							end
							else
								state_reg <= ppc_pkg::ST_IDLE;
						end
					ppc_pkg::ST_ADDR_ACK:
					begin
						bit_cnt_reg <= 4'h0;
						if (rw_reg)
						begin
							state_reg  <= ppc_pkg::ST_RDATA;
							shift_reg  <= rd_data;
							sda_oe_reg <= !rd_data[7];
						end
						else
						begin
							state_reg  <= ppc_pkg::ST_REG;
							sda_oe_reg <= 1'b0;
						end
					end
					ppc_pkg::ST_REG:
						if (bit_cnt_reg == 4'h8)
						begin
							ptr_reg    <= shift_reg;
							state_reg  <= ppc_pkg::ST_REG_ACK;
							sda_oe_reg <= 1'b1;
						end
					ppc_pkg::ST_WDATA:
						if (bit_cnt_reg == 4'h8)
						begin
							wr_reg     <= 1'b1;
							state_reg  <= ppc_pkg::ST_WDATA_ACK;
							sda_oe_reg <= 1'b1;
						end
					ppc_pkg::ST_REG_ACK,
					ppc_pkg::ST_WDATA_ACK:
					begin
						if (state_reg == ppc_pkg::ST_WDATA_ACK)
							ptr_reg <= ptr_reg + 8'h01;
						sda_oe_reg  <= 1'b0;
						bit_cnt_reg <= 4'h0;
						state_reg   <= ppc_pkg::ST_WDATA;
					end
					ppc_pkg::ST_RDATA:
						if (bit_cnt_reg == 4'h7)
						begin
							state_reg  <= ppc_pkg::ST_RDATA_ACK;
							sda_oe_reg <= 1'b0;
							ptr_reg    <= ptr_reg + 8'h01;
						end
						else
						begin
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
							shift_reg   <= {shift_reg[6:0], 1'b0};
							sda_oe_reg  <= !shift_reg[6];
						end
					ppc_pkg::ST_RDATA_ACK:
						if (nack_reg)
							state_reg <= ppc_pkg::ST_IDLE;
						else
						begin
							state_reg   <= ppc_pkg::ST_RDATA;
							bit_cnt_reg <= 4'h0;
							shift_reg   <= rd_data;
							sda_oe_reg  <= !rd_data[7];
						end
				endcase
			end
		end
	end

	assign serial_data_drive_pin    = 1'b0;
	assign serial_data_drive_pin_oe = sda_oe_reg;

	// ****************************************************************
	// registers
	// ****************************************************************
	assign wr_pb = wr_reg && ptr_reg == ppc_pkg::REG_PUSHBUTTON;

	always_comb
	begin
		case (ptr_reg)
			ppc_pkg::REG_INT_EVENT:   rd_data = ev_reg;
			ppc_pkg::REG_INT_MASK:    rd_data = mask_reg;
			ppc_pkg::REG_PIN_STATUS:  rd_data = {7'h00, auto_lvl};
			ppc_pkg::REG_PORT_CTRL:   rd_data = ctrl_reg;
			ppc_pkg::REG_PORT_STATUS: rd_data = {gate_on, pg};
			default:                  rd_data = 8'h00;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst_int)
			mask_reg <= auto_lvl ? ppc_pkg::MASK_RST_AUTO : ppc_pkg::MASK_RST_MANUAL;
		else if (wr_reg && ptr_reg == ppc_pkg::REG_INT_MASK)
			mask_reg <= shift_reg;
	end

	always_comb
	begin
		ctrl_next = ctrl_reg;
		if (wr_reg && ptr_reg == ppc_pkg::REG_PORT_CTRL)
			ctrl_next = shift_reg;
		ctrl_next[3:0] = ctrl_next[3:0] & ~(~shut_lvl | tstart_ev | ticut_ev);
		if (wr_pb)
			ctrl_next[3:0] = ctrl_next[3:0] & ~shift_reg[3:0];
	end

	always_ff @(posedge clk)
	begin
		if (rst_int)
			ctrl_reg <= auto_lvl ? ppc_pkg::PORT_CTRL_RST_AUTO :
				ppc_pkg::PORT_CTRL_RST_MANUAL;
		else
			ctrl_reg <= ctrl_next;
	end

	// ****************************************************************
	// events and interrupt pin
	// ****************************************************************
	always_comb
	begin
		ev_set = 8'h00;
		ev_set[ppc_pkg::EV_TSTART]  = |tstart_ev;
		ev_set[ppc_pkg::EV_TICUT]   = |ticut_ev;
		ev_set[ppc_pkg::EV_PGOOD]   = |pg_ev;
		ev_set[ppc_pkg::EV_PENABLE] = |pe_ev;
		ev_clr = 8'h00;
		if (wr_pb && (shift_reg[ppc_pkg::PB_INT_LO] || shift_reg[ppc_pkg::PB_INT_HI]))
			ev_clr = 8'hff;
	end

	always_ff @(posedge clk)
	begin
		if (rst_int)
			ev_reg <= ppc_pkg::INT_EVENT_RST;
		else
			ev_reg <= (ev_reg & ~ev_clr) | ev_set;
	end

	always_ff @(posedge clk)
	begin
		if (rst_int)
			int_oe_reg <= 1'b0;
		else if (!busy_reg)
			int_oe_reg <= |(ev_reg & mask_reg);
	end

	assign int_pin    = 1'b0;
	assign int_pin_oe = int_oe_reg;

	// ****************************************************************
	// checks
	// ****************************************************************
	int_quiet_a: assert property (@(posedge clk) disable iff (rst_int)
		(busy_reg && $past(busy_reg)) |-> $stable(int_oe_reg))
		else $error("interrupt pin moved during a transaction");

	int_masked_a: assert property (@(posedge clk) disable iff (rst_int)
		$rose(int_oe_reg) |-> $past(|(ev_reg & mask_reg)))
		else $error("interrupt asserted by a masked event");

	int_pull_a: assert property (@(posedge clk) disable iff (rst_int)
		(!busy_reg && |(ev_reg & mask_reg)) |=> int_oe_reg)
		else $error("enabled event did not pull interrupt low");

	int_release_a: assert property (@(posedge clk) disable iff (rst_int)
		(wr_pb && (shift_reg[ppc_pkg::PB_INT_LO] || shift_reg[ppc_pkg::PB_INT_HI])) |=>
		ev_reg == $past(ev_set))
		else $error("pushbutton clear did not clear the events");

	int_drop_a: assert property (@(posedge clk) disable iff (rst_int)
		(!busy_reg && (ev_reg & mask_reg) == 8'h00) |=> !int_oe_reg)
		else $error("interrupt not released with no enabled event");

	addr_match_a: assert property (@(posedge clk) disable iff (rst_int)
		(state_reg == ppc_pkg::ST_ADDR_ACK) |-> $past(shift_reg[7:1]) == dev_addr)
		else $error("acknowledged a foreign address");

	shut_off_a: assert property (@(posedge clk) disable iff (rst_int)
		(shut_lvl != 4'hf) |=> (ctrl_reg[3:0] & ~$past(shut_lvl)) == 4'h0 ##1
		(gate_on & ~$past(shut_lvl, 2)) == 4'h0)
		else $error("shut down port stayed enabled");

	strap_default_a: assert property (@(posedge clk)
		$fell(rst_int) |-> mask_reg == (auto_lvl ? ppc_pkg::MASK_RST_AUTO :
		ppc_pkg::MASK_RST_MANUAL))
		else $error("mask default does not follow auto strap");

	mask_write_a: assert property (@(posedge clk) disable iff (rst_int)
		(wr_reg && ptr_reg == ppc_pkg::REG_INT_MASK) |=> mask_reg == $past(shift_reg))
		else $error("mask write lost");

	reset_off_a: assert property (@(posedge clk)
		(rst_int && $past(rst_int)) |-> gate_on == 4'h0 && ev_reg == ppc_pkg::INT_EVENT_RST)
		else $error("port powered during chip reset");
endmodule

// File: dv/ppc_host.sv
// serial bus master standing in for the host processor
// assumes a pulled-up data line; scl and data change only after clk edges
`timescale 1ns/100ps
module ppc_host (
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_pull
);
	// ****************************************************************
	// bit and byte level
	// ****************************************************************
	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda_pull <= ~b;
		hold(10);
		scl <= 1'b1;
		hold(10);
		r = sda;
		scl <= 1'b0;
		hold(1);
	endtask
	task automatic start();
		sda_pull <= 1'b0;
		hold(10);
		scl <= 1'b1;
		hold(10);
		sda_pull <= 1'b1;
		hold(10);
		scl <= 1'b0;
		hold(1);
	endtask
	task automatic stop();
		sda_pull <= 1'b1;
		hold(10);
		scl <= 1'b1;
		hold(10);
		sda_pull <= 1'b0;
		hold(20);
	endtask
	task automatic tx(input logic [7:0] d, output logic nak);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, nak);
	endtask
	task automatic rx(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask
	// ****************************************************************
	// register transactions
	// ****************************************************************
	task automatic wr(input logic [6:0] a, input logic [7:0] p, d, output logic nak);
		logic n1;
		logic n2;
		start();
		tx({a, 1'b0}, nak);
		tx(p, n1);
		tx(d, n2);
		stop();
		nak = nak | n1 | n2;
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d);
		logic n;
		start();
		tx({a, 1'b0}, n);
		tx(p, n);
		start();
		tx({a, 1'b1}, n);
		rx(1'b1, d);
		stop();
	endtask
endmodule

// File: dv/ppc_top_tb.sv
// self-checking bench of the port controller control block
// assumes ppc_host as bus master, auto strap driven here, FAULT_CYC cut to 20
`timescale 1ns/100ps
module ppc_top_tb;
	localparam int FC = 20;
	logic       clk, sys_rst, chip_reset_n, scl, sda_pull, osc, sda, oe, int_oe, ack;
	logic       sdo, ipin, irq_n, auto;
	logic [3:0] strap, shut_n, cut, clamp, vlow, fet, thr, pg, probe;
	logic [6:0] dev;
	logic [6:0] bad [5] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h20};
	logic [7:0] v, m;
	int         p, error_cnt, n_checks;
	assign sda   = ~sda_pull & (oe ? sdo : 1'b1);
	assign irq_n = int_oe ? ipin : 1'b1;
	ppc_top #(.FAULT_CYC(FC)) u_dut (.clk, .sys_rst, .chip_reset_n, .scl,
		.serial_data_sense_pin(sda), .serial_data_drive_pin(sdo), .serial_data_drive_pin_oe(oe),
		.int_pin(ipin), .int_pin_oe(int_oe), .bus_addr_strap_msb(strap[3]),
		.bus_addr_strap_2(strap[2]), .bus_addr_strap_1(strap[1]),
		.bus_addr_strap_lsb(strap[0]), .auto_mode_strap(auto), .port_shutoff_n(shut_n),
		.port_current_monitor_cut(cut), .port_current_monitor_clamp(clamp),
		.port_voltage_monitor_low(vlow), .ac_probe_oscillator_input(osc),
		.port_fet_drive(fet), .port_fet_throttle(thr), .port_power_good(pg),
		.port_probe_pin(probe));
	ppc_host u_host (.clk, .sda, .scl, .sda_pull);
	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic end_of_test();
		if (error_cnt == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial
	begin
		cyc(90000);
		error_cnt++;
		end_of_test();
	end
	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial
	begin
		{sys_rst, chip_reset_n, osc, shut_n, cut, clamp, vlow} = {3'b110, 4'hf, 12'h000};
		auto = 1'b1;
		error_cnt = 0;
		n_checks = 0;
		void'($urandom(32'hfeaf9353));
		strap = 4'($urandom);
		dev = {ppc_pkg::ADDR_PREFIX, strap};
		cyc(8);
		sys_rst <= 1'b0;
		cyc(60);
		chk(fet, 4'hf);
		chk(irq_n, 1'b0);
		u_host.rd(dev, ppc_pkg::REG_INT_MASK, v);
		chk(v, ppc_pkg::MASK_RST_AUTO);
		u_host.rd(dev, ppc_pkg::REG_PIN_STATUS, v);
		chk(v, 8'h01);
		for (int i = 0; i < 5; i++)
		begin
			u_host.wr(dev ^ bad[i], ppc_pkg::REG_INT_MASK, 8'h00, ack);
			chk(ack, 1'b1);
		end
		m = 8'($urandom);
		u_host.wr(dev, ppc_pkg::REG_INT_MASK, m, ack);
		chk(ack, 1'b0);
		u_host.rd(dev, ppc_pkg::REG_INT_MASK, v);
		chk(v, m);
		u_host.wr(dev, ppc_pkg::REG_PUSHBUTTON, ($urandom & 1) ? 8'h40 : 8'h80, ack);
		chk(irq_n, 1'b1);
		u_host.wr(dev, ppc_pkg::REG_INT_MASK, 8'hbe, ack);
		p = $urandom_range(3);
		cut[p] <= 1'b1;
		cyc(FC - 6);
		cut[p] <= 1'b0;
		cyc(6);
		chk(fet[p], 1'b1);
		cut[p] <= 1'b1;
		cyc(FC + 10);
		cut[p] <= 1'b0;
		chk(fet[p], 1'b0);
		chk(irq_n, 1'b1);
		u_host.wr(dev, ppc_pkg::REG_INT_MASK, 8'h40, ack);
		chk(irq_n, 1'b0);
		u_host.rd(dev, ppc_pkg::REG_INT_EVENT, v);
		chk(v[6], 1'b1);
		u_host.wr(dev, ppc_pkg::REG_PORT_CTRL, 8'hff, ack);
		clamp[p] <= 1'b1;
		vlow[p] <= 1'b1;
		cyc(6);
		chk(thr[p], 1'b1);
		chk(pg[p], 1'b1);
		{clamp, vlow} <= 8'h00;
		for (int i = 0; i < 4; i++)
		begin
			osc <= ~osc;
			cyc(8);
			chk(probe, {4{osc}});
		end
		shut_n[p] <= 1'b0;
		cyc(20);
		shut_n[p] <= 1'b1;
		cyc(10);
		chk(fet[p], 1'b1);
		shut_n[p] <= 1'b0;
		cyc(60);
		shut_n[p] <= 1'b1;
		cyc(50);
		chk(fet[p], 1'b0);
		chip_reset_n <= 1'b0;
		cyc(20);
		chip_reset_n <= 1'b1;
		cyc(10);
		u_host.rd(dev, ppc_pkg::REG_INT_MASK, v);
		chk(v, 8'h40);
		chip_reset_n <= 1'b0;
		cyc(60);
		chk(fet, 4'h0);
		chip_reset_n <= 1'b1;
		cyc(60);
		u_host.rd(dev, ppc_pkg::REG_INT_MASK, v);
		chk(v, ppc_pkg::MASK_RST_AUTO);
		chk(fet, 4'hf);
		auto <= 1'b0;
		chip_reset_n <= 1'b0;
		cyc(60);
		chip_reset_n <= 1'b1;
		cyc(60);
		chk(irq_n, 1'b0);
		chk(fet, 4'h0);
		u_host.rd(dev, ppc_pkg::REG_INT_MASK, v);
		chk(v, ppc_pkg::MASK_RST_MANUAL);
		u_host.rd(dev, ppc_pkg::REG_PIN_STATUS, v);
		chk(v, 8'h00);
		end_of_test();
	end
endmodule
